// ### hw/perf_count_pkg.sv
// Constants shared by the event counting block: widths, event numbers and reset values.
// Assumes the core pipeline supplies event occurrences on the same clock.
package perf_count_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int COUNTERS   = 4;
  localparam int CNT_W      = 64;
  localparam int SEL_W      = 6;
  localparam int NUM_EVENTS = 51;
  localparam int INC_W      = 2;

  // ---------------------------------------------------------------
  // Event numbers
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] EV_NONE    = 6'h00;
  localparam logic [SEL_W-1:0] EV_CYCLES  = 6'h01;
  localparam logic [SEL_W-1:0] EV_MAX     = 6'h32;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic             RST_GROUP_EN = 1'b1;
  localparam logic [SEL_W-1:0] RST_SEL      = 6'h00;
  localparam logic [CNT_W-1:0] RST_COUNT    = 64'h0;

endpackage : perf_count_pkg

// ### hw/event_select_limit.sv
// Clamps a selector write to the highest supported event number.
// Assumes the write data comes from CSR logic on the same clock.
`timescale 1ns/1ps
module event_select_limit
(
  // Raw value
  input  wire logic [31:0]                   writeData,
  // Legal value
  output logic      [perf_count_pkg::SEL_W-1:0] legalSel
);
  wire tooLarge;

  assign tooLarge = writeData > 32'(perf_count_pkg::EV_MAX);
  assign legalSel = tooLarge ? perf_count_pkg::EV_MAX
                             : writeData[perf_count_pkg::SEL_W-1:0];
endmodule : event_select_limit

// ### hw/event_mux.sv
// Selects the occurrence count of one event from the flattened event vector.
// Assumes entry 0 of the vector is tied to zero by the caller.
`timescale 1ns/1ps
module event_mux
(
  // Event occurrences, two bits per event
  input  wire logic [perf_count_pkg::NUM_EVENTS*perf_count_pkg::INC_W-1:0] eventCounts,
  // Selector
  input  wire logic [perf_count_pkg::SEL_W-1:0]                             sel,
  // Selected increment
  output logic      [perf_count_pkg::INC_W-1:0]                             inc
);
  wire inRange;

  assign inRange = sel <= perf_count_pkg::EV_MAX;
  assign inc     = inRange ? eventCounts[sel*perf_count_pkg::INC_W +: perf_count_pkg::INC_W]
                           : 2'h0;
endmodule : event_mux

// ### hw/perf_event_select_count.sv
// Four 64-bit event counters with per-counter event selectors and a group enable.
// Assumes event inputs and CSR strobes are driven by core logic on ref_clk.
//
// Operation
// - Selector writes above event fifty store fifty instead.
// - Selector zero selects nothing; counter holds.
// - Event one counts every active clock cycle.
// - Events two and three count instruction cache hits and misses.
// - Events four to six count committed instructions, all, 16-bit, 32-bit.
// - Events seven and eight count aligned and decoded instructions.
// - Events nine to fourteen count muls, divs, loads, stores, misaligned ones.
// - Event fifteen counts committed ALU operations including nop and wfi.
// - Events sixteen to eighteen count the three CSR instruction kinds.
// - Events nineteen to twenty-three count ebreak, ecall, fence, fence.i, mret.
// - Events twenty-four to twenty-seven count branch kinds.
// - Events twenty-eight to thirty-two count front-end stall cycles.
// - Events thirty-three to thirty-six count freeze, buffer and DMA stalls.
// - Events thirty-seven to thirty-nine count exceptions, timer and external interrupts.
// - Events forty and forty-one count trap logic and branch error flushes.
// - Events forty-two to forty-six count bus transactions and errors.
// - Events forty-seven and forty-eight count instruction and data bus busy stalls.
// - Events forty-nine and fifty count interrupt-disabled and stalled cycles.
// - Group enable bit, reset one, gates all counters without changing values.
// - Each counter is 64 bits wide.
// - Counter increments after a read but before a write takes effect.
// - Halt state stops all counting, cycle counter included.
`timescale 1ns/1ps
module perf_event_select_count
(
  // Clock and reset
  input  wire logic                                        ref_clk,
  input  wire logic                                        rst,
  // Power management or firmware halt
  input  wire logic                                        coreHalted,
  // Instruction cache and front end
  input  wire logic                                        icacheHit,
  input  wire logic                                        icacheMiss,
  input  wire logic [1:0]                                  commitAll,
  input  wire logic [1:0]                                  commit16,
  input  wire logic [1:0]                                  commit32,
  input  wire logic [1:0]                                  alignedInstr,
  input  wire logic [1:0]                                  decodedInstr,
  // Committed single events
  input  wire logic                                        mulCommit,
  input  wire logic                                        divCommit,
  input  wire logic                                        loadCommit,
  input  wire logic                                        storeCommit,
  input  wire logic                                        misalignedLoad,
  input  wire logic                                        misalignedStore,
  input  wire logic [1:0]                                  aluCommit,
  input  wire logic                                        csrReadCommit,
  input  wire logic                                        csrReadWriteCommit,
  input  wire logic                                        csrWriteRd0Commit,
  input  wire logic                                        ebreakCommit,
  input  wire logic                                        ecallCommit,
  input  wire logic                                        fenceCommit,
  input  wire logic                                        fenceiCommit,
  input  wire logic                                        mretCommit,
  // Branches
  input  wire logic                                        branchCommit,
  input  wire logic                                        branchMispredict,
  input  wire logic                                        branchTaken,
  input  wire logic                                        branchUnpredictable,
  // Stall cycles
  input  wire logic                                        fetchStall,
  input  wire logic                                        alignerStall,
  input  wire logic                                        decodeStall,
  input  wire logic                                        postsyncStall,
  input  wire logic                                        presyncStall,
  input  wire logic                                        loadStoreUnitFreeze,
  input  wire logic                                        storeBufferStall,
  input  wire logic                                        dmaDataStall,
  input  wire logic                                        dmaFetchStall,
  // Traps and flushes
  input  wire logic                                        exceptionTaken,
  input  wire logic                                        timerIntTaken,
  input  wire logic                                        extIntTaken,
  input  wire logic                                        trapLogicUnitFlush,
  input  wire logic                                        branchErrorFlush,
  // Bus events
  input  wire logic                                        instrBusTrans,
  input  wire logic                                        dataBusTrans,
  input  wire logic                                        dataBusMisaligned,
  input  wire logic                                        instrBusError,
  input  wire logic                                        dataBusError,
  input  wire logic                                        instrBusBusy,
  input  wire logic                                        dataBusBusy,
  // Interrupt enable state
  input  wire logic                                        intDisabled,
  input  wire logic                                        intStalledDisabled,
  // CSR access to group enable
  input  wire logic                                        groupEnWrite,
  input  wire logic                                        groupEnData,
  // CSR access to selectors and counters
  input  wire logic [1:0]                                  csrIndex,
  input  wire logic                                        selWrite,
  input  wire logic [31:0]                                 selData,
  input  wire logic                                        cntWriteLo,
  input  wire logic                                        cntWriteHi,
  input  wire logic [31:0]                                 cntData,
  // State seen by software
  output logic                                             groupEnable,
  output logic [perf_count_pkg::COUNTERS*perf_count_pkg::SEL_W-1:0] eventSel,
  output logic [perf_count_pkg::COUNTERS*perf_count_pkg::CNT_W-1:0] counterValue
);

  // ---------------------------------------------------------------
  // Event vector
  // ---------------------------------------------------------------
  // One-bit events widen to two bits so every entry has the same slot.
  localparam int EVW = perf_count_pkg::NUM_EVENTS * perf_count_pkg::INC_W;

  wire [EVW-1:0] eventCounts;
  wire [1:0]     cycleTick;

  assign cycleTick = 2'h1;

  assign eventCounts = {
    {1'b0, intStalledDisabled},
    {1'b0, intDisabled},
    {1'b0, dataBusBusy},
    {1'b0, instrBusBusy},
    {1'b0, dataBusError},
    {1'b0, instrBusError},
    {1'b0, dataBusMisaligned},
    {1'b0, dataBusTrans},
    {1'b0, instrBusTrans},
    {1'b0, branchErrorFlush},
    {1'b0, trapLogicUnitFlush},
    {1'b0, extIntTaken},
    {1'b0, timerIntTaken},
    {1'b0, exceptionTaken},
    {1'b0, dmaFetchStall},
    {1'b0, dmaDataStall},
    {1'b0, storeBufferStall},
    {1'b0, loadStoreUnitFreeze},
    {1'b0, presyncStall},
    {1'b0, postsyncStall},
    {1'b0, decodeStall},
    {1'b0, alignerStall},
    {1'b0, fetchStall},
    {1'b0, branchUnpredictable},
    {1'b0, branchTaken},
    {1'b0, branchMispredict},
    {1'b0, branchCommit},
    {1'b0, mretCommit},
    {1'b0, fenceiCommit},
    {1'b0, fenceCommit},
    {1'b0, ecallCommit},
    {1'b0, ebreakCommit},
    {1'b0, csrWriteRd0Commit},
    {1'b0, csrReadWriteCommit},
    {1'b0, csrReadCommit},
    aluCommit,
    {1'b0, misalignedStore},
    {1'b0, misalignedLoad},
    {1'b0, storeCommit},
    {1'b0, loadCommit},
    {1'b0, divCommit},
    {1'b0, mulCommit},
    decodedInstr,
    alignedInstr,
    commit32,
    commit16,
    commitAll,
    {1'b0, icacheMiss},
    {1'b0, icacheHit},
    cycleTick,
    2'h0
  };

  // ---------------------------------------------------------------
  // Group enable
  // ---------------------------------------------------------------
  // Halt suspends counting but leaves software's enable choice intact.
  wire countEnable;

  assign countEnable = groupEnable & ~coreHalted;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      groupEnable <= perf_count_pkg::RST_GROUP_EN;
    else if (groupEnWrite)
      groupEnable <= groupEnData;
  end

  // ---------------------------------------------------------------
  // Selector clamp
  // ---------------------------------------------------------------
  wire [perf_count_pkg::SEL_W-1:0] legalSel;

  event_select_limit u_limit
  (
    .writeData (selData),
    .legalSel  (legalSel)
  );

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < perf_count_pkg::COUNTERS; gi++)
    begin : g_cnt
      logic [perf_count_pkg::SEL_W-1:0] sel;
      logic [perf_count_pkg::CNT_W-1:0] count;
      wire  [perf_count_pkg::INC_W-1:0] inc;
      wire  [perf_count_pkg::CNT_W-1:0] bumped;
      wire  [perf_count_pkg::CNT_W-1:0] next_count;
      wire                              hit;

      event_mux u_mux
      (
        .eventCounts (eventCounts),
        .sel         (sel),
        .inc         (inc)
      );

      assign hit    = csrIndex == 2'(gi);
      // Increment first, then let a write replace the half it targets.
      assign bumped = countEnable ? count + 64'(inc) : count;
      assign next_count = (hit & cntWriteLo) ? {bumped[63:32], cntData} :
                          (hit & cntWriteHi) ? {cntData, bumped[31:0]}  :
                          bumped;

      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          sel   <= perf_count_pkg::RST_SEL;
          count <= perf_count_pkg::RST_COUNT;
        end
        else
        begin
          if (hit & selWrite)
            sel <= legalSel;
          count <= next_count;
        end
      end

      assign eventSel[gi*perf_count_pkg::SEL_W +: perf_count_pkg::SEL_W]      = sel;
      assign counterValue[gi*perf_count_pkg::CNT_W +: perf_count_pkg::CNT_W]  = count;
    end
  endgenerate

endmodule : perf_event_select_count

// ### testbench/perf_event_select_count_chk.sv
// Concurrent checks on the event counter block, bound to its top module.
// Assumes one clock domain, ref_clk, with async reset rst.
`timescale 1ns/1ps
module perf_event_select_count_chk
(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         rst,
  // Controls
  input wire logic         coreHalted,
  input wire logic         groupEnWrite,
  input wire logic         groupEnData,
  input wire logic [1:0]   csrIndex,
  input wire logic         selWrite,
  input wire logic [31:0]  selData,
  input wire logic         cntWriteLo,
  input wire logic         cntWriteHi,
  input wire logic [31:0]  cntData,
  // State
  input wire logic         groupEnable,
  input wire logic [23:0]  eventSel,
  input wire logic [255:0] counterValue
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  wire logic noCntWr = !cntWriteLo && !cntWriteHi;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_sel_clamp; selWrite && selData > 32'h32 |=> eventSel[$past(csrIndex)*6 +: 6] == 6'h32; endproperty
  a_sel_clamp: assert property (p_sel_clamp) else $error("selector not clamped");
  property p_sel_hold; !selWrite |=> $stable(eventSel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selector changed unwritten");
  property p_sel_zero; eventSel[5:0] == 6'h00 && noCntWr |=> $stable(counterValue[63:0]); endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("idle selector counted");
  property p_cycles;
    eventSel[11:6] == 6'h01 && groupEnable && !coreHalted && noCntWr
      |=> counterValue[127:64] == $past(counterValue[127:64]) + 64'h1;
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle event missed a cycle");
  property p_group_off; !groupEnable && noCntWr |=> $stable(counterValue); endproperty
  a_group_off: assert property (p_group_off) else $error("counted while group off");
  property p_group_wr; groupEnWrite |=> groupEnable == $past(groupEnData); endproperty
  a_group_wr: assert property (p_group_wr) else $error("group enable write lost");
  property p_halt; coreHalted && noCntWr |=> $stable(counterValue); endproperty
  a_halt: assert property (p_halt) else $error("counted while halted");
  property p_wr_lo; cntWriteLo |=> counterValue[$past(csrIndex)*64 +: 32] == $past(cntData); endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low half write lost");
  property p_wr_hi;
    cntWriteHi && !cntWriteLo |=> counterValue[$past(csrIndex)*64+32 +: 32] == $past(cntData);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high half write lost");
  c_clamp: cover property (selWrite && selData > 32'h32);
  c_halt: cover property (coreHalted && groupEnable);
  c_write_live: cover property (cntWriteLo && groupEnable);
endmodule : perf_event_select_count_chk

bind perf_event_select_count perf_event_select_count_chk i_chk (.ref_clk(ref_clk), .rst(rst),
  .coreHalted(coreHalted), .groupEnWrite(groupEnWrite), .groupEnData(groupEnData),
  .csrIndex(csrIndex), .selWrite(selWrite), .selData(selData), .cntWriteLo(cntWriteLo),
  .cntWriteHi(cntWriteHi), .cntData(cntData), .groupEnable(groupEnable),
  .eventSel(eventSel), .counterValue(counterValue));

// ### testbench/perf_event_source.sv
// Model of the pipeline event sources: one event slot active at a time.
// Assumes the bench sets the event number and count on the clock edge.
`timescale 1ns/1ps
module perf_event_source
(
  // Event choice
  input  wire logic [5:0]   evNum,
  input  wire logic [1:0]   evVal,
  // Two bits per event number, slot 0 unused
  output logic      [101:0] e
);
  // Only one slot lit, so a wrong mux lane reads zero and shows up
  assign e = 102'(evVal) << (2 * evNum);
endmodule : perf_event_source

// ### testbench/perf_event_select_count_tb.sv
// Self-checking bench for the event counter block.
// Assumes the source model feeds every event input from one slotted vector.
`timescale 1ns/1ps
module perf_event_select_count_tb;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         coreHalted = 1'b0;
  logic         groupEnWrite = 1'b0;
  logic         groupEnData = 1'b0;
  logic [1:0]   csrIndex = 2'h0;
  logic         selWrite = 1'b0;
  logic         cntWriteLo = 1'b0;
  logic         cntWriteHi = 1'b0;
  logic [31:0]  wrData = 32'h0;
  logic [5:0]   evNum = 6'h00;
  logic [1:0]   evVal = 2'h0;
  logic [101:0] e;
  logic         groupEnable;
  logic [23:0]  eventSel;
  logic [255:0] counterValue;
  int           failures = 0;
  int           nTests = 0;
  always #12.5 ref_clk = ~ref_clk;
  perf_event_source i_src (.evNum(evNum), .evVal(evVal), .e(e));
  perf_event_select_count i_dut (.ref_clk(ref_clk), .rst(rst), .coreHalted(coreHalted),
    .icacheHit(e[4]), .icacheMiss(e[6]), .commitAll(e[9:8]), .commit16(e[11:10]),
    .commit32(e[13:12]), .alignedInstr(e[15:14]), .decodedInstr(e[17:16]), .mulCommit(e[18]),
    .divCommit(e[20]), .loadCommit(e[22]), .storeCommit(e[24]), .misalignedLoad(e[26]),
    .misalignedStore(e[28]), .aluCommit(e[31:30]), .csrReadCommit(e[32]),
    .csrReadWriteCommit(e[34]), .csrWriteRd0Commit(e[36]), .ebreakCommit(e[38]),
    .ecallCommit(e[40]), .fenceCommit(e[42]), .fenceiCommit(e[44]), .mretCommit(e[46]),
    .branchCommit(e[48]), .branchMispredict(e[50]), .branchTaken(e[52]),
    .branchUnpredictable(e[54]), .fetchStall(e[56]), .alignerStall(e[58]),
    .decodeStall(e[60]), .postsyncStall(e[62]), .presyncStall(e[64]),
    .loadStoreUnitFreeze(e[66]), .storeBufferStall(e[68]), .dmaDataStall(e[70]),
    .dmaFetchStall(e[72]), .exceptionTaken(e[74]), .timerIntTaken(e[76]), .extIntTaken(e[78]),
    .trapLogicUnitFlush(e[80]), .branchErrorFlush(e[82]), .instrBusTrans(e[84]),
    .dataBusTrans(e[86]), .dataBusMisaligned(e[88]), .instrBusError(e[90]),
    .dataBusError(e[92]), .instrBusBusy(e[94]), .dataBusBusy(e[96]), .intDisabled(e[98]),
    .intStalledDisabled(e[100]), .groupEnWrite(groupEnWrite), .groupEnData(groupEnData),
    .csrIndex(csrIndex), .selWrite(selWrite), .selData(wrData), .cntWriteLo(cntWriteLo),
    .cntWriteHi(cntWriteHi), .cntData(wrData), .groupEnable(groupEnable),
    .eventSel(eventSel), .counterValue(counterValue));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic csr(input logic s, input logic lo, input logic hi, input logic [1:0] idx,
                     input logic [31:0] d);
    @(posedge ref_clk);
    {selWrite, cntWriteLo, cntWriteHi} <= {s, lo, hi};
    csrIndex <= idx;
    wrData   <= d;
    @(posedge ref_clk);
    {selWrite, cntWriteLo, cntWriteHi} <= 3'h0;
  endtask : csr
  // Selector, then each half: both halves at once would let the low half win
  task automatic setup(input int c, input logic [31:0] sel, input logic [63:0] v);
    csr(1'b1, 1'b0, 1'b0, 2'(c), sel);
    csr(1'b0, 1'b1, 1'b0, 2'(c), v[31:0]);
    csr(1'b0, 1'b0, 1'b1, 2'(c), v[63:32]);
  endtask : setup
  task automatic group(input logic en);
    @(posedge ref_clk);
    groupEnWrite <= 1'b1;
    groupEnData  <= en;
    @(posedge ref_clk);
    groupEnWrite <= 1'b0;
  endtask : group
  // Counting spans n + 2 edges: the disabling write still sees the group on
  task automatic window(input int n);
    group(1'b1);
    repeat (n) @(posedge ref_clk);
    group(1'b0);
  endtask : window
  function automatic logic [63:0] cv(input int c);
    return counterValue[c*64 +: 64];
  endfunction : cv
  task automatic print_verdict;
    if (failures == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("group enable", 64'(groupEnable), 64'h1);
    chk("selectors", 64'(eventSel), 64'h0);
    for (int c = 0; c < 4; c++)
      chk("reset count", cv(c), 64'h0);
  endtask : t_reset
  task automatic t_clamp;
    logic [31:0] vals [5] = '{32'h33, 32'h3f, 32'hffffffff, 32'h32, 32'h31};
    foreach (vals[i])
    begin
      csr(1'b1, 1'b0, 1'b0, 2'h2, vals[i]);
      @(negedge ref_clk);
      chk("selector", 64'(eventSel[17:12]), (i == 4) ? 64'h31 : 64'h32);
    end
  endtask : t_clamp
  task automatic t_events;
    int v;
    for (int k = 1; k <= 50; k++)
    begin
      v = (k inside {[4:8], 15}) ? 2 : 1;
      setup(k % 4, 32'(k), 64'h0);
      @(posedge ref_clk);
      evNum <= 6'(k);
      evVal <= 2'(v);
      window(3);
      evVal <= 2'h0;
      @(negedge ref_clk);
      chk("count", cv(k%4), 64'(5*v));
    end
  endtask : t_events
  task automatic t_misc;
    setup(0, 32'h0, 64'h5a);
    window(4);
    @(negedge ref_clk);
    chk("idle selector", cv(0), 64'h5a);
    setup(1, 32'h1, 64'h0);
    coreHalted <= 1'b1;
    window(2);
    coreHalted <= 1'b0;
    @(negedge ref_clk);
    chk("halted count", cv(1), 64'h0);
    setup(2, 32'h1, 64'hffffffffffffffff);
    window(0);
    @(negedge ref_clk);
    chk("wrap", cv(2), 64'h1);
    setup(3, 32'h1, 64'h0);
    group(1'b1);
    repeat (3) @(posedge ref_clk);
    csr(1'b0, 1'b1, 1'b0, 2'h3, 32'h100);
    group(1'b0);
    group(1'b1);
    csr(1'b0, 1'b0, 1'b1, 2'h3, 32'h7);
    group(1'b0);
    @(negedge ref_clk);
    chk("live write", cv(3), 64'h0000000700000106);
  endtask : t_misc
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    t_reset();
    group(1'b0);
    t_clamp();
    t_events();
    t_misc();
    print_verdict();
  end
  initial
  begin
    #(25 * 5000);
    failures++;
    print_verdict();
  end
endmodule : perf_event_select_count_tb
